/* src/psc_pkg.sv */
// package for the port-three serial and control block
`default_nettype none
package psc_pkg;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 2;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] LAST_STOP_IDX = 4'h1;

  typedef enum logic [1:0] {PSC_IDLE, PSC_START, PSC_DATA, PSC_STOP} psc_state_t;

  // mode selects for the dedicated functions
  typedef struct packed {
    logic serial_en;
    logic parity_en;
    logic timer_en;
    logic p0_hs_en;
    logic p2_hs_en;
    logic dm_en;
  } psc_cfg_t;

  // general-purpose output levels used where no dedicated function is chosen
  typedef struct packed {
    logic line7;
    logic line6;
    logic line5;
    logic line4;
  } psc_gpo_t;

  typedef struct packed {
    psc_state_t st;
    logic [3:0] idx;
    logic [7:0] sh;
  } psc_chan_t;

  typedef struct packed {
    psc_chan_t tx;
    psc_chan_t rx;
    logic txd;
    logic rx_par;
    logic [7:0] rx_byte;
    logic rx_irq;
    logic tx_irq;
    logic tx_busy;
  } psc_state_all_t;
endpackage : psc_pkg
`default_nettype wire

/* src/psc_port3.sv */
// port-three dedicated functions: serial transmit/receive and control line routing
`default_nettype none
// Behaviour
// R1 - four fixed inputs, four fixed outputs
// R2 - serial in line 0, out line 7
// R3 - bit rate from counter/timer 0 ticks
// R4 - one start bit, two stop bits
// R5 - always eight data bit periods
// R6 - parity mode: bit 7 is odd parity
// R7 - one transmit interrupt per character
// R8 - sender frames start, eight data, stop
// R9 - parity mode: bit 7 carries parity error
// R10 - receive interrupt shares line 0 request
// R11 - inputs map to interrupt requests 3,2,0,1
// R12 - timer input line 1, output line 6
// R13 - handshake pairs for ports 0 and 2
// R14 - line 4 drives data-memory select low
// R15 - no parity: byte unchanged, no error
module psc_port3 (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_p3_in,
  input wire psc_pkg::psc_cfg_t i_cfg,
  input wire psc_pkg::psc_gpo_t i_gpo,
  input wire logic i_t0_tick,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_timer_out,
  input wire logic i_p0_ready,
  input wire logic i_p2_ready,
  input wire logic i_data_mem_cycle,
  output logic o_tx_ready,
  output logic [3:0] o_p3_out,
  output logic o_ext_irq_req0,
  output logic o_ext_irq_req1,
  output logic o_ext_irq_req2,
  output logic o_ext_irq_req3_rx,
  output logic o_tx_done_irq,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_counter_timer_one_in,
  output logic o_port0_handshake_dav_n,
  output logic o_port2_handshake_dav_n
);
  psc_pkg::psc_state_all_t s;
  psc_pkg::psc_state_all_t next_s;
  logic p3_in_line0;
  logic p3_in_line1;
  logic p3_in_line2;
  logic p3_in_line3;
  logic [7:0] tx_word;

  // fixed-direction input lines, no direction register exists [R1]
  assign p3_in_line0 = i_p3_in[0];
  assign p3_in_line1 = i_p3_in[1];
  assign p3_in_line2 = i_p3_in[2];
  assign p3_in_line3 = i_p3_in[3];

  // odd parity over the low seven bits replaces bit 7 [R6]
  assign tx_word = i_cfg.parity_en ? {~^i_tx_data[6:0], i_tx_data[6:0]} : i_tx_data;
  assign o_tx_ready = i_cfg.serial_en && !s.tx_busy;

  // next-state logic for both serial channels, stepped on timer 0 ticks except byte accept and serial disable
  always_comb
  begin
    next_s = s;
    next_s.tx_irq = 1'b0;
    next_s.rx_irq = 1'b0;
    if (!i_cfg.serial_en)
    begin
      next_s.tx.st = psc_pkg::PSC_IDLE;
      next_s.rx.st = psc_pkg::PSC_IDLE;
      next_s.tx_busy = 1'b0;
      next_s.txd = 1'b1;
    end
    else
    begin
      // accepting a byte only latches it; the line moves on the next tick
      if (i_tx_valid && !s.tx_busy)
      begin
        next_s.tx_busy = 1'b1;
        next_s.tx.sh = tx_word;
        next_s.tx.st = psc_pkg::PSC_START;
      end
      if (i_t0_tick) // [R3]
      begin
        case (s.tx.st)
          psc_pkg::PSC_IDLE:
          begin
            next_s.txd = 1'b1;
          end
          psc_pkg::PSC_START:
          begin
            next_s.txd = 1'b0; // [R4]
            next_s.tx.idx = psc_pkg::CNT_RESET;
            next_s.tx.st = psc_pkg::PSC_DATA;
          end
          psc_pkg::PSC_DATA:
          begin
            // eight data periods whatever the parity mode [R5]
            next_s.txd = s.tx.sh[0];
            next_s.tx.sh = {1'b0, s.tx.sh[7:1]};
            next_s.tx.idx = s.tx.idx + 4'h1;
            if (s.tx.idx == psc_pkg::LAST_DATA_IDX)
            begin
              next_s.tx.idx = psc_pkg::CNT_RESET;
              next_s.tx.st = psc_pkg::PSC_STOP;
            end
          end
          default:
          begin
            // two stop periods appended by hardware [R4]
            next_s.txd = 1'b1;
            next_s.tx.idx = s.tx.idx + 4'h1;
            if (s.tx.idx == psc_pkg::LAST_STOP_IDX)
            begin
              next_s.tx.st = psc_pkg::PSC_IDLE;
              next_s.tx_busy = 1'b0;
              next_s.tx_irq = 1'b1; // [R7]
            end
          end
        endcase
        // no mid-bit alignment: the far end must hold each bit across its tick
        // receiver samples line 0 once per tick; sender keeps the framing [R2] [R8]
        case (s.rx.st)
          psc_pkg::PSC_IDLE:
          begin
            if (!p3_in_line0)
            begin
              next_s.rx.st = psc_pkg::PSC_DATA;
              next_s.rx.idx = psc_pkg::CNT_RESET;
              next_s.rx_par = 1'b0;
            end
          end
          psc_pkg::PSC_DATA:
          begin
            next_s.rx.sh = {p3_in_line0, s.rx.sh[7:1]};
            next_s.rx_par = s.rx_par ^ p3_in_line0;
            next_s.rx.idx = s.rx.idx + 4'h1;
            if (s.rx.idx == psc_pkg::LAST_DATA_IDX)
            begin
              next_s.rx.st = psc_pkg::PSC_STOP;
            end
          end
          default:
          begin
            // one stop bit is enough; the byte is presented here
            next_s.rx.st = psc_pkg::PSC_IDLE;
            next_s.rx_irq = 1'b1; // [R10]
            if (i_cfg.parity_en)
            begin
              // odd parity over all eight bits: even count is an error [R9]
              next_s.rx_byte = {~(s.rx_par), s.rx.sh[6:0]};
            end
            else
            begin
              next_s.rx_byte = s.rx.sh; // [R15]
            end
          end
        endcase
      end
    end
  end

  // single state register, synchronous reset
  // the line rests high out of reset so the peer never sees a false start
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      s <= '0;
      s.txd <= 1'b1;
      s.tx.sh <= psc_pkg::BYTE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // output line routing; handshake wins over timer on line 6 [R1]
  // a line that no function claims shows its general-purpose level
  always_comb
  begin
    o_p3_out = {i_gpo.line7, i_gpo.line6, i_gpo.line5, i_gpo.line4};
    if (i_cfg.dm_en)
    begin
      o_p3_out[0] = !i_data_mem_cycle; // [R14]
    end
    if (i_cfg.p0_hs_en)
    begin
      o_p3_out[1] = i_p0_ready; // [R13]
    end
    if (i_cfg.p2_hs_en)
    begin
      o_p3_out[2] = i_p2_ready; // [R13]
    end
    else if (i_cfg.timer_en)
    begin
      o_p3_out[2] = i_timer_out; // [R12]
    end
    if (i_cfg.serial_en)
    begin
      o_p3_out[3] = s.txd; // [R2]
    end
  end

  // interrupt request mapping [R11]
  assign o_ext_irq_req0 = !p3_in_line2;
  assign o_ext_irq_req1 = !p3_in_line3;
  assign o_ext_irq_req2 = !p3_in_line1;
  assign o_ext_irq_req3_rx = i_cfg.serial_en ? s.rx_irq : !p3_in_line0; // [R10]
  // pulses come straight from flops and stand for exactly one clock
  assign o_tx_done_irq = s.tx_irq;
  assign o_rx_data = s.rx_byte;
  assign o_rx_valid = s.rx_irq;
  assign o_counter_timer_one_in = i_cfg.timer_en ? p3_in_line1 : 1'b0; // [R12]
  assign o_port0_handshake_dav_n = i_cfg.p0_hs_en ? p3_in_line2 : 1'b1; // [R13]
  assign o_port2_handshake_dav_n = i_cfg.p2_hs_en ? p3_in_line1 : 1'b1; // [R13]
endmodule : psc_port3
`default_nettype wire

/* verif/psc_port3_monitor.sv */
// checker for the port-three block
`default_nettype none
module psc_port3_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_p3_in,
  input wire psc_pkg::psc_cfg_t i_cfg,
  input wire psc_pkg::psc_gpo_t i_gpo,
  input wire logic i_timer_out,
  input wire logic i_p0_ready,
  input wire logic i_p2_ready,
  input wire logic i_data_mem_cycle,
  input wire logic o_tx_ready,
  input wire logic [3:0] o_p3_out,
  input wire logic o_ext_irq_req0,
  input wire logic o_ext_irq_req1,
  input wire logic o_ext_irq_req2,
  input wire logic o_ext_irq_req3_rx,
  input wire logic o_tx_done_irq,
  input wire logic o_rx_valid,
  input wire logic o_counter_timer_one_in,
  input wire logic o_port0_handshake_dav_n,
  input wire logic o_port2_handshake_dav_n
);
  timeunit 1ns / 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // pins are active low, requests active high
  irq_zero_a: assert property (o_ext_irq_req0 == !i_p3_in[2]) else $error("req0");
  irq_one_a: assert property (o_ext_irq_req1 == !i_p3_in[3]) else $error("req1");
  irq_two_a: assert property (o_ext_irq_req2 == !i_p3_in[1]) else $error("req2");
  timer_in_a: assert property (i_cfg.timer_en |->
    o_counter_timer_one_in == i_p3_in[1]) else $error("timer in");
  timer_out_a: assert property (i_cfg.timer_en && !i_cfg.p2_hs_en |->
    o_p3_out[2] == i_timer_out) else $error("timer out");
  mem_sel_a: assert property (i_cfg.dm_en |-> o_p3_out[0] == !i_data_mem_cycle)
    else $error("mem select");
  hs_zero_a: assert property (i_cfg.p0_hs_en |->
    o_port0_handshake_dav_n == i_p3_in[2]) else $error("handshake");
  hs_two_a: assert property (i_cfg.p2_hs_en |->
    o_port2_handshake_dav_n == i_p3_in[1]) else $error("handshake two");
  line_five_a: assert property (i_cfg.p0_hs_en |->
    o_p3_out[1] == i_p0_ready) else $error("line five");
  line_six_a: assert property (i_cfg.p2_hs_en |->
    o_p3_out[2] == i_p2_ready) else $error("line six");
  gpo_seven_a: assert property (!i_cfg.serial_en |->
    o_p3_out[3] == i_gpo.line7) else $error("line seven");
  line_idle_a: assert property (o_tx_ready |-> o_p3_out[3]) else $error("tx idle");
  irq_pin_a: assert property (!i_cfg.serial_en |->
    o_ext_irq_req3_rx == !i_p3_in[0]) else $error("req3 pin");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid) else $error("rx pulse");
  done_pulse_a: assert property (o_tx_done_irq |=> !o_tx_done_irq) else $error("done");
  rx_irq_a: assert property (o_rx_valid && i_cfg.serial_en |-> o_ext_irq_req3_rx)
    else $error("rx irq");
  cover property (o_tx_done_irq);
  cover property (o_rx_valid && i_cfg.parity_en);
  cover property (i_data_mem_cycle && i_cfg.dm_en);
  cover property (i_cfg.p2_hs_en && i_p2_ready);
endmodule : psc_port3_monitor
bind psc_port3 psc_port3_monitor psc_port3_monitor_i (.*);
`default_nettype wire

/* verif/psc_peer.sv */
// remote serial transceiver model
`default_nettype none
module psc_peer (
  input wire logic i_mclk,
  input wire logic i_tick,
  input wire logic i_line,
  output logic o_line
);
  timeunit 1ns / 1ns;
  initial o_line = 1'b1;
  // start, eight data lsb first, one stop; line rests high after
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      @(posedge i_mclk iff i_tick);
      o_line <= f[k];
    end
  endtask : send
  // one sample per tick: start, eight data, two stops
  task recv(output logic [10:0] f);
    @(posedge i_mclk iff (i_tick && i_line === 1'b0));
    f[0] = 1'b0;
    for (int k = 1; k < 11; k++)
    begin
      @(posedge i_mclk iff i_tick);
      f[k] = i_line;
    end
  endtask : recv
endmodule : psc_peer
`default_nettype wire

/* verif/psc_port3_bench.sv */
// self-checking bench for the port-three block
`default_nettype none
module psc_port3_bench;
  timeunit 1ns / 1ns;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_t0_tick = 1'b0, i_tx_valid = 1'b0;
  logic i_p0_ready = 1'b0, i_data_mem_cycle = 1'b0, rxd, o_tx_ready, o_tx_done_irq, o_rx_valid;
  logic [7:0] i_tx_data = 8'h00, o_rx_data;
  logic i_timer_out = 1'b0, i_p2_ready = 1'b0;
  logic [3:1] in_hi = 3'h7;
  logic [1:0] tcnt = 2'h0;
  logic [3:0] o_p3_out;
  logic [10:0] fr;
  psc_pkg::psc_cfg_t i_cfg = 6'h2D;
  int mismatches = 0, cmp_count = 0, ndone = 0, cyc = 0;
  psc_port3 psc_port3_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_p3_in({in_hi, rxd}),
    .i_cfg(i_cfg), .i_gpo(4'hA), .i_t0_tick(i_t0_tick), .i_tx_valid(i_tx_valid),
    .i_tx_data(i_tx_data), .i_timer_out(i_timer_out), .i_p0_ready(i_p0_ready),
    .i_p2_ready(i_p2_ready),
    .i_data_mem_cycle(i_data_mem_cycle), .o_tx_ready(o_tx_ready), .o_p3_out(o_p3_out),
    .o_ext_irq_req0(), .o_ext_irq_req1(), .o_ext_irq_req2(), .o_ext_irq_req3_rx(),
    .o_tx_done_irq(o_tx_done_irq), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
    .o_counter_timer_one_in(), .o_port0_handshake_dav_n(), .o_port2_handshake_dav_n());
  psc_peer psc_peer_i (.i_mclk(i_mclk), .i_tick(i_t0_tick), .i_line(o_p3_out[3]), .o_line(rxd));
  initial
  begin
    forever #20 i_mclk = ~i_mclk;
  end
  // tick every fourth clock keeps frames short; done pulses counted; hang guard
  always @(posedge i_mclk)
  begin
    tcnt <= tcnt + 2'h1;
    i_t0_tick <= (tcnt == 2'h3);
    ndone <= ndone + int'(o_tx_done_irq === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task chk(input string n, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task finish_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // send one byte, capture the whole frame at the line, count done pulses
  task tx(input logic p, input logic [7:0] d, input logic [7:0] e);
    int n;
    n = ndone;
    @(negedge i_mclk iff o_tx_ready);
    @(posedge i_mclk);
    i_cfg.parity_en <= p;
    i_tx_valid <= 1'b1;
    i_tx_data <= d;
    fork
      psc_peer_i.recv(fr);
      @(posedge i_mclk) i_tx_valid <= 1'b0;
    join
    repeat (8) @(posedge i_mclk);
    chk("frame", {2'b11, e, 1'b0}, fr);
    chk("done", 11'(n + 1), 11'(ndone));
  endtask : tx
  // peer sends one byte; expect valid and data within a few ticks
  task rx(input logic p, input logic [7:0] d, input logic [7:0] e);
    @(posedge i_mclk);
    i_cfg.parity_en <= p;
    psc_peer_i.send(d);
    for (int k = 0; k < 12 && o_rx_valid !== 1'b1; k++)
      @(negedge i_mclk);
    chk("rx", {3'b001, e}, {2'b00, o_rx_valid, o_rx_data});
  endtask : rx
  // main sequence
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_mclk);
      in_hi <= 3'(k);
      {i_p0_ready, i_data_mem_cycle} <= 2'(k);
      {i_timer_out, i_p2_ready} <= 2'(k / 2);
      // odd steps keep the serial setup, even ones hand line 6 to port 2
      i_cfg <= (k % 2 == 1) ? 6'h2D : 6'h0A;
    end
    tx(1'b0, 8'hA5, 8'hA5);
    tx(1'b0, 8'h80, 8'h80);
    tx(1'b1, 8'h03, 8'h83);
    tx(1'b1, 8'h87, 8'h07);
    rx(1'b0, 8'h3C, 8'h3C);
    rx(1'b0, 8'h81, 8'h81);
    rx(1'b1, 8'h83, 8'h03);
    rx(1'b1, 8'h03, 8'h83);
    finish_test();
  end
endmodule : psc_port3_bench
`default_nettype wire
